// ---- core/sshm_mailbox.sv ----
// host mailbox of the sdio slave: status, sent length, shared words, vectors
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps

// Function
// - masked status bit per source reads raw and enable both set
// - check field equals length bits 9:0 plus bits 19:10
// - hold sent length total; host copy refreshed only on host read
// - shared words at 0x6C to 0x7C, 0x88 and 0x9C to 0xB8 read and written by both sides
// - host-to-slave vector bits stay until a later write changes them
// - raw status bit per source set by its event, whatever the enable
// - host writes one to a clear bit to drop that interrupt
// - enable bit per source gates raw status into masked status
// - slave rings host doorbells by writing the slave-to-host vector
module sshm_mailbox (
  // clock and reset
  input  wire logic                SYS_CLK_IN,
  input  wire logic                RST_IN,
  // host register port
  input  wire sshm_pkg::sshm_req_t HOST_REQ_IN,
  output logic              [31:0] HOST_RDATA_OUT,
  // slave register port
  input  wire sshm_pkg::sshm_req_t SLAVE_REQ_IN,
  output logic              [31:0] SLAVE_RDATA_OUT,
  // slave-side event pulses
  input  wire logic                NEW_PKT_IN,
  input  wire logic                RX_OVF_IN,
  input  wire logic                TX_UDF_IN,
  // state seen by host link and slave
  output logic                     HOST_IRQ_OUT,
  output logic              [31:0] H2S_VEC_OUT
);
  import sshm_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  sshm_top_st_t        s_q;
  sshm_top_st_t        s_d;
  logic [31:0]         word_q [N_SHARED];
  logic [N_SHARED-1:0] h_hit;
  logic [N_SHARED-1:0] s_hit;
  logic [LEN_W-1:0]    acc_q;
  logic [LEN_W-1:0]    snap_q;
  logic [CHK_W-1:0]    chk;
  logic                h_len_rd;
  logic                len_inc;
  logic                h_clr_wr;
  logic                h_ena_wr;
  logic                h_h2s_wr;
  logic                s_bell_wr;

  // ****************************************
  // strobe decode
  // ****************************************
  assign h_len_rd  = HOST_REQ_IN.rd && (HOST_REQ_IN.addr == OFS_LEN);
  assign h_clr_wr  = HOST_REQ_IN.wr && (HOST_REQ_IN.addr == OFS_CLR);
  assign h_ena_wr  = HOST_REQ_IN.wr && (HOST_REQ_IN.addr == OFS_ENA);
  assign h_h2s_wr  = HOST_REQ_IN.wr && (HOST_REQ_IN.addr == OFS_H2S);
  assign s_bell_wr = SLAVE_REQ_IN.wr && (SLAVE_REQ_IN.addr == OFS_DOORBELL);
  assign len_inc   = SLAVE_REQ_IN.wr && (SLAVE_REQ_IN.addr == OFS_LEN_INC)
                     && SLAVE_REQ_IN.wdata[LEN_INC_BIT];

  // ****************************************
  // sent length
  // ****************************************
  sshm_len_acc #(
    .LEN_W (LEN_W)
  ) u_len (
    .clk_in     (SYS_CLK_IN),
    .rst_in     (RST_IN),
    .inc_in     (len_inc),
    .inc_val_in (SLAVE_REQ_IN.wdata[LEN_W-1:0]),
    .snap_in    (h_len_rd),
    .acc_out    (acc_q),
    .snap_out   (snap_q)
  );

  assign chk = {1'b0, acc_q[LEN_HALF-1:0]} + {1'b0, acc_q[LEN_W-1:LEN_HALF]};

  // ****************************************
  // shared words
  // ****************************************
  for (genvar i = 0; i < N_SHARED; i++) begin : g_word
    assign h_hit[i] = HOST_REQ_IN.addr == SHARED_OFS[i];
    assign s_hit[i] = SLAVE_REQ_IN.addr == SHARED_OFS[i];
    sshm_shared_word #(
      .BYTE_EN (SHARED_BYTES[i])
    ) u_word (
      .clk_in        (SYS_CLK_IN),
      .rst_in        (RST_IN),
      .host_wr_in    (HOST_REQ_IN.wr && h_hit[i]),
      .host_data_in  (HOST_REQ_IN.wdata),
      .slave_wr_in   (SLAVE_REQ_IN.wr && s_hit[i]),
      .slave_data_in (SLAVE_REQ_IN.wdata),
      .word_out      (word_q[i])
    );
  end

  // ****************************************
  // status, vectors and read data
  // ****************************************
  // clear first, then events, so an event in the clear cycle survives
  always_comb begin
    s_d = s_q;
    s_d.hrd = 32'h0000_0000;
    s_d.srd = 32'h0000_0000;
    if (h_clr_wr) begin
      s_d.raw = s_q.raw & ~HOST_REQ_IN.wdata;
    end
    if (NEW_PKT_IN) begin
      s_d.raw[BIT_NEWPKT] = 1'b1;
    end
    if (RX_OVF_IN) begin
      s_d.raw[BIT_OVF] = 1'b1;
    end
    if (TX_UDF_IN) begin
      s_d.raw[BIT_UDF] = 1'b1;
    end
    if (s_bell_wr) begin
      s_d.raw[DOORBELL_W-1:0] = s_d.raw[DOORBELL_W-1:0]
                                | SLAVE_REQ_IN.wdata[DOORBELL_W-1:0];
    end
    s_d.raw = s_d.raw & IRQ_MASK;
    if (h_ena_wr) begin
      s_d.ena = HOST_REQ_IN.wdata & IRQ_MASK;
    end
    if (h_h2s_wr) begin
      s_d.h2s = HOST_REQ_IN.wdata & H2S_MASK;
    end
    s_d.st  = s_d.raw & s_d.ena;
    s_d.irq = |s_d.st;
    // host reads; write-only words read zero
    if (HOST_REQ_IN.rd) begin
      if (HOST_REQ_IN.addr == OFS_RAW) begin
        s_d.hrd = s_q.raw;
      end else if (HOST_REQ_IN.addr == OFS_ST) begin
        s_d.hrd = s_q.st;
      end else if (HOST_REQ_IN.addr == OFS_LEN) begin
        // host sees the total taken now
        s_d.hrd = {1'b0, chk, acc_q};
      end else if (HOST_REQ_IN.addr == OFS_ENA) begin
        s_d.hrd = s_q.ena;
      end else begin
        for (int k = 0; k < N_SHARED; k++) begin
          if (h_hit[k]) begin
            s_d.hrd = word_q[k];
          end
        end
      end
    end
    // slave reads
    if (SLAVE_REQ_IN.rd) begin
      if (SLAVE_REQ_IN.addr == OFS_H2S) begin
        s_d.srd = s_q.h2s;
      end else if (SLAVE_REQ_IN.addr == OFS_LEN_SUM) begin
        s_d.srd = {{(32-LEN_W){1'b0}}, acc_q};
      end else if (SLAVE_REQ_IN.addr == OFS_LEN) begin
        s_d.srd = {{(32-LEN_W){1'b0}}, snap_q};
      end else begin
        for (int k = 0; k < N_SHARED; k++) begin
          if (s_hit[k]) begin
            s_d.srd = word_q[k];
          end
        end
      end
    end
  end

  // state register
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      s_q <= TOP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops
  assign HOST_RDATA_OUT  = s_q.hrd;
  assign SLAVE_RDATA_OUT = s_q.srd;
  assign HOST_IRQ_OUT    = s_q.irq;
  assign H2S_VEC_OUT     = s_q.h2s;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);

  property p_masked_read;
    HOST_REQ_IN.rd && HOST_REQ_IN.addr == OFS_ST
      |=> HOST_RDATA_OUT == ($past(s_q.raw) & $past(s_q.ena));
  endproperty
  a_masked_read: assert property (p_masked_read) else $error("masked status wrong");

  property p_check_field;
    h_len_rd |=> HOST_RDATA_OUT[CHK_LSB +: CHK_W]
                 == HOST_RDATA_OUT[9:0] + HOST_RDATA_OUT[19:10];
  endproperty
  a_check_field: assert property (p_check_field) else $error("length check wrong");

  property p_len_read;
    h_len_rd |=> HOST_RDATA_OUT[LEN_W-1:0] == $past(acc_q);
  endproperty
  a_len_read: assert property (p_len_read) else $error("length read stale");

  property p_vec_hold;
    !h_h2s_wr |=> $stable(s_q.h2s);
  endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("vector changed by itself");

  sequence s_pkt_evt;
    NEW_PKT_IN;
  endsequence
  property p_raw_set;
    s_pkt_evt |=> s_q.raw[BIT_NEWPKT] && (s_q.st[BIT_NEWPKT] == s_q.ena[BIT_NEWPKT]);
  endproperty
  a_raw_set: assert property (p_raw_set) else $error("event lost");

  sequence s_ovf_clear;
    h_clr_wr && HOST_REQ_IN.wdata[BIT_OVF] && !RX_OVF_IN;
  endsequence
  property p_clear;
    s_ovf_clear |=> !s_q.raw[BIT_OVF] && (HOST_IRQ_OUT == |(s_q.raw & s_q.ena));
  endproperty
  a_clear: assert property (p_clear) else $error("clear ignored");

  property p_enable;
    h_ena_wr |=> s_q.ena == ($past(HOST_REQ_IN.wdata) & IRQ_MASK)
                 && HOST_IRQ_OUT == |(s_q.raw & s_q.ena);
  endproperty
  a_enable: assert property (p_enable) else $error("enable not taken");

  property p_doorbell;
    s_bell_wr && SLAVE_REQ_IN.wdata[0] |=> s_q.raw[0];
  endproperty
  a_doorbell: assert property (p_doorbell) else $error("doorbell not raised");

  property p_vec_gaps;
    (H2S_VEC_OUT & ~H2S_MASK) == 32'h0000_0000;
  endproperty
  a_vec_gaps: assert property (p_vec_gaps) else $error("vector gap holds data");

  // an event beside a clear of its own bit must survive
  sequence s_pkt_clash;
    h_clr_wr && HOST_REQ_IN.wdata[BIT_NEWPKT] && NEW_PKT_IN;
  endsequence
  property p_set_wins;
    s_pkt_clash |=> s_q.raw[BIT_NEWPKT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

  property p_ovf_set;
    RX_OVF_IN |=> s_q.raw[BIT_OVF];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow event lost");

  property p_udf_set;
    TX_UDF_IN |=> s_q.raw[BIT_UDF];
  endproperty
  a_udf_set: assert property (p_udf_set) else $error("underflow event lost");

  property p_irq_level;
    HOST_IRQ_OUT == |(s_q.raw & s_q.ena);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("host irq level wrong");

  property p_raw_gaps;
    (s_q.raw & ~IRQ_MASK) == 32'h0000_0000;
  endproperty
  a_raw_gaps: assert property (p_raw_gaps) else $error("raw status gap set");

  property p_vec_take;
    h_h2s_wr |=> H2S_VEC_OUT == ($past(HOST_REQ_IN.wdata) & H2S_MASK);
  endproperty
  a_vec_take: assert property (p_vec_take) else $error("vector write not taken");

  property p_vec_slave_read;
    SLAVE_REQ_IN.rd && SLAVE_REQ_IN.addr == OFS_H2S
      |=> SLAVE_RDATA_OUT == $past(H2S_VEC_OUT);
  endproperty
  a_vec_slave_read: assert property (p_vec_slave_read) else $error("vector read wrong");

  property p_copy_read;
    SLAVE_REQ_IN.rd && SLAVE_REQ_IN.addr == OFS_LEN
      |=> SLAVE_RDATA_OUT == {{(32-LEN_W){1'b0}}, $past(snap_q)};
  endproperty
  a_copy_read: assert property (p_copy_read) else $error("host copy read wrong");

  property p_wo_read;
    HOST_REQ_IN.rd && (HOST_REQ_IN.addr == OFS_H2S || HOST_REQ_IN.addr == OFS_CLR)
      |=> HOST_RDATA_OUT == 32'h0000_0000;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only word read nonzero");

  // read data stands one cycle only, so a stale word never lingers
  property p_hread_idle;
    !HOST_REQ_IN.rd |=> HOST_RDATA_OUT == 32'h0000_0000;
  endproperty
  a_hread_idle: assert property (p_hread_idle) else $error("host read data lingers");

  property p_sread_idle;
    !SLAVE_REQ_IN.rd |=> SLAVE_RDATA_OUT == 32'h0000_0000;
  endproperty
  a_sread_idle: assert property (p_sread_idle) else $error("slave read data lingers");

endmodule

// ---- core/sshm_pkg.sv ----
// package: register map, field layout and state types of the host mailbox
package sshm_pkg;

  // ****************************************
  // widths and counts
  // ****************************************
  localparam int ADDR_W     = 8;
  localparam int LEN_W      = 20;
  localparam int CHK_W      = 11;
  localparam int CHK_LSB    = 20;
  localparam int LEN_HALF   = 10;
  localparam int DOORBELL_W = 8;
  localparam int N_SHARED   = 14;

  // ****************************************
  // host side offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_RAW = 8'h50;
  localparam logic [ADDR_W-1:0] OFS_ST  = 8'h58;
  localparam logic [ADDR_W-1:0] OFS_LEN = 8'h60;
  localparam logic [ADDR_W-1:0] OFS_H2S = 8'h8C;
  localparam logic [ADDR_W-1:0] OFS_CLR = 8'hD4;
  localparam logic [ADDR_W-1:0] OFS_ENA = 8'hDC;

  // ****************************************
  // slave side offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_DOORBELL = 8'h4C;
  localparam logic [ADDR_W-1:0] OFS_LEN_INC  = 8'hE4;
  localparam logic [ADDR_W-1:0] OFS_LEN_SUM  = 8'hE8;

  // shared words, same offsets from both sides, with the bytes that exist
  localparam logic [ADDR_W-1:0] SHARED_OFS [N_SHARED] = '{
    8'h6C, 8'h70, 8'h74, 8'h78, 8'h7C, 8'h88, 8'h9C,
    8'hA0, 8'hA4, 8'hA8, 8'hAC, 8'hB0, 8'hB4, 8'hB8};
  localparam logic [3:0] SHARED_BYTES [N_SHARED] = '{
    4'hF, 4'hF, 4'hF, 4'hC, 4'hC, 4'hF, 4'hF,
    4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF};

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_OVF     = 16;
  localparam int BIT_UDF     = 17;
  localparam int BIT_NEWPKT  = 23;
  localparam int LEN_INC_BIT = 31;
  localparam logic [31:0] IRQ_MASK = 32'h008300FF;
  localparam logic [31:0] H2S_MASK = 32'hFF00FF00;

  // ****************************************
  // carriers and state
  // ****************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } sshm_req_t;

  typedef struct packed {
    logic [31:0] word;
  } sshm_word_st_t;

  typedef struct packed {
    logic [LEN_W-1:0] acc;
    logic [LEN_W-1:0] snap;
  } sshm_len_st_t;

  typedef struct packed {
    logic [31:0] raw;
    logic [31:0] ena;
    logic [31:0] st;
    logic [31:0] h2s;
    logic [31:0] hrd;
    logic [31:0] srd;
    logic        irq;
  } sshm_top_st_t;

  // values after reset
  localparam sshm_word_st_t WORD_RST = '0;
  localparam sshm_len_st_t  LEN_RST  = '0;
  localparam sshm_top_st_t  TOP_RST  = '0;

endpackage

// ---- core/sshm_shared_word.sv ----
// one shared information word written from both sides
`timescale 1ns/10ps
module sshm_shared_word #(
  parameter logic [3:0] BYTE_EN = 4'hF
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // write from the host and from the slave
  input  wire logic        host_wr_in,
  input  wire logic [31:0] host_data_in,
  input  wire logic        slave_wr_in,
  input  wire logic [31:0] slave_data_in,
  // stored word
  output logic      [31:0] word_out
);
  import sshm_pkg::*;

  sshm_word_st_t s_q;
  sshm_word_st_t s_d;
  logic [31:0]   mask;

  // byte enables widened to a bit mask
  assign mask = {{8{BYTE_EN[3]}}, {8{BYTE_EN[2]}}, {8{BYTE_EN[1]}}, {8{BYTE_EN[0]}}};

  // host wins a same-cycle clash; missing bytes never store
  always_comb begin
    s_d = s_q;
    if (host_wr_in) begin
      s_d.word = host_data_in & mask;
    end else if (slave_wr_in) begin
      s_d.word = slave_data_in & mask;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= WORD_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign word_out = s_q.word;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_host_store;
    host_wr_in |=> word_out == ($past(host_data_in) & mask);
  endproperty
  a_host_store: assert property (p_host_store) else $error("host write not stored");

  property p_slave_store;
    slave_wr_in && !host_wr_in |=> word_out == ($past(slave_data_in) & mask);
  endproperty
  a_slave_store: assert property (p_slave_store) else $error("slave write not stored");

  property p_gap_zero;
    (word_out & ~mask) == 32'h0000_0000;
  endproperty
  a_gap_zero: assert property (p_gap_zero) else $error("missing byte holds data");

endmodule

// ---- core/sshm_len_acc.sv ----
// accumulated send length with the copy of the total that the host last read
`timescale 1ns/10ps
module sshm_len_acc #(
  parameter int LEN_W = 20
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // slave adds a sent length
  input  wire logic             inc_in,
  input  wire logic [LEN_W-1:0] inc_val_in,
  // host read of the length refreshes its copy
  input  wire logic             snap_in,
  // running total and host copy
  output logic      [LEN_W-1:0] acc_out,
  output logic      [LEN_W-1:0] snap_out
);
  import sshm_pkg::*;

  sshm_len_st_t s_q;
  sshm_len_st_t s_d;

  // total wraps at the field width, as the field has no overflow flag
  always_comb begin
    s_d = s_q;
    if (inc_in) begin
      s_d.acc = LEN_W'(s_q.acc + inc_val_in);
    end
    if (snap_in) begin
      s_d.snap = s_q.acc;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= LEN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign acc_out  = s_q.acc;
  assign snap_out = s_q.snap;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_snap_hold;
    !snap_in |=> $stable(snap_out);
  endproperty
  a_snap_hold: assert property (p_snap_hold) else $error("host copy moved without read");

  property p_snap_take;
    snap_in |=> snap_out == $past(acc_out);
  endproperty
  a_snap_take: assert property (p_snap_take) else $error("host copy not refreshed");

  property p_acc_add;
    inc_in |=> acc_out == LEN_W'($past(acc_out) + $past(inc_val_in));
  endproperty
  a_acc_add: assert property (p_acc_add) else $error("sent length not added");

endmodule

// ---- test/sshm_host_model.sv ----
// partner model: issues register transfers on one mailbox port, used for both the host and the slave side
`timescale 1ns/10ps
module sshm_host_model (
  // clock
  input  wire logic           clk_in,
  // register request toward the mailbox
  output sshm_pkg::sshm_req_t req_out
);
  import sshm_pkg::*;

  // ****************************************
  // transfers
  // ****************************************
  // bus starts idle so nothing is taken during reset
  initial req_out = '0;

  // one request per call, launched after an edge and taken at the next
  task automatic go(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    req_out <= '{addr: a, wdata: d, wr: w, rd: r};
  endtask

  // released bus shows inverted leftovers, so a stale copy is never read
  task automatic idle();
    go(1'b0, 1'b0, ~req_out.addr, ~req_out.wdata);
  endtask
endmodule

// ---- test/tb_top.sv ----
// self-checking bench of the host mailbox
`timescale 1ns/10ps
module tb_top;
  import sshm_pkg::*;

  // ****************************************
  // signals
  // ****************************************
  logic        sys_clk;
  logic        rst;
  logic        new_pkt;
  logic        rx_ovf;
  logic        tx_udf;
  sshm_req_t   host_req;
  sshm_req_t   slave_req;
  logic [31:0] host_rdata;
  logic [31:0] slave_rdata;
  logic [31:0] h2s_vec;
  logic        host_irq;
  logic        h_taken;
  logic        s_taken;
  logic [31:0] hq[$];
  logic [31:0] sq[$];
  logic [31:0] d;
  logic [31:0] e;
  logic [31:0] raw;
  logic [19:0] l1;
  logic [19:0] l2;
  int          miscompares = 0;
  int          n_compared = 0;

  // 25 MHz system clock
  always #20 sys_clk = ~sys_clk;

  sshm_mailbox dut_u (
    .SYS_CLK_IN(sys_clk), .RST_IN(rst), .HOST_REQ_IN(host_req),
    .HOST_RDATA_OUT(host_rdata), .SLAVE_REQ_IN(slave_req),
    .SLAVE_RDATA_OUT(slave_rdata), .NEW_PKT_IN(new_pkt), .RX_OVF_IN(rx_ovf),
    .TX_UDF_IN(tx_udf), .HOST_IRQ_OUT(host_irq), .H2S_VEC_OUT(h2s_vec));
  sshm_host_model host_u (.clk_in(sys_clk), .req_out(host_req));
  sshm_host_model slave_u (.clk_in(sys_clk), .req_out(slave_req));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // the side not addressed is released in the same cycle, so no strobe repeats
  task automatic op(input bit slv, input logic w, input logic [7:0] a, input logic [31:0] v);
    if (slv) fork slave_u.go(w, !w, a, v); host_u.idle(); join
    else fork host_u.go(w, !w, a, v); slave_u.idle(); join
  endtask

  task automatic wr(input bit slv, input logic [7:0] a, input logic [31:0] v);
    op(slv, 1'b1, a, v);
  endtask

  task automatic rd(input bit slv, input logic [7:0] a, input logic [31:0] x);
    if (slv) sq.push_back(x);
    else hq.push_back(x);
    op(slv, 1'b0, a, $urandom);
  endtask

  task automatic quiet();
    fork host_u.idle(); slave_u.idle(); join
  endtask

  task automatic tdone(input string s);
    quiet();
    $display("test %s finished", s);
  endtask

  function automatic logic [31:0] bmask(input logic [3:0] b);
    for (int k = 0; k < 4; k++) bmask[8*k +: 8] = {8{b[k]}};
  endfunction

  function automatic logic [31:0] lenword(input logic [19:0] t);
    logic [10:0] c;
    c = t[9:0] + t[19:10];
    lenword = {1'b0, c, t};
  endfunction

  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ****************************************
  // answer watcher
  // ****************************************
  // an answer belongs to the read taken at the previous edge, else it is zero
  always @(posedge sys_clk) begin
    h_taken <= host_req.rd;
    s_taken <= slave_req.rd;
  end
  always @(negedge sys_clk) begin
    if (!rst) begin
      chk(host_rdata, h_taken ? hq.pop_front() : 32'h0);
      chk(slave_rdata, s_taken ? sq.pop_front() : 32'h0);
    end
  end

  // hang guard at 5000 cycles, far beyond the roughly 120 cycles the tests need
  initial begin
    #(40 * 5000);
    miscompares++;
    stop_test();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {new_pkt, rx_ovf, tx_udf} = 3'b000;
    void'($urandom(53965));
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd(0, OFS_ST, 32'h0);
    rd(0, OFS_LEN, 32'h0);
    rd(1, OFS_H2S, 32'h0);
    rd(0, 8'h00, 32'h0);
    tdone("reset");
    for (int i = 0; i < N_SHARED; i++) begin
      d = $urandom;
      wr(0, SHARED_OFS[i], d);
      rd(1, SHARED_OFS[i], d & bmask(SHARED_BYTES[i]));
      d = $urandom;
      wr(1, SHARED_OFS[i], d);
      rd(0, SHARED_OFS[i], d & bmask(SHARED_BYTES[i]));
    end
    fork
      host_u.go(1'b1, 1'b0, SHARED_OFS[7], 32'h1234ABCD);
      slave_u.go(1'b1, 1'b0, SHARED_OFS[7], 32'h0);
    join
    rd(1, SHARED_OFS[7], 32'h1234ABCD);
    tdone("shared");
    e = $urandom | 32'h1;
    wr(0, OFS_ENA, e);
    wr(1, OFS_DOORBELL, 32'hA5);
    quiet();
    {new_pkt, rx_ovf, tx_udf} <= 3'b111;
    quiet();
    {new_pkt, rx_ovf, tx_udf} <= 3'b000;
    raw = 32'h008300A5;
    rd(0, OFS_RAW, raw);
    rd(0, OFS_ST, raw & e);
    rd(0, OFS_ENA, e & IRQ_MASK);
    @(negedge sys_clk);
    chk({31'h0, host_irq}, {31'h0, |(raw & e)});
    // partial clear, event in the clear cycle wins
    wr(0, OFS_CLR, 32'h00810001);
    new_pkt <= 1'b1;
    quiet();
    new_pkt <= 1'b0;
    rd(0, OFS_RAW, 32'h008200A4);
    wr(0, OFS_CLR, 32'hFFFFFFFF);
    rd(0, OFS_RAW, 32'h0);
    rd(0, OFS_ST, 32'h0);
    quiet();
    @(negedge sys_clk);
    chk({31'h0, host_irq}, 32'h0);
    tdone("status");
    l1 = 20'($urandom);
    l2 = 20'($urandom);
    wr(1, OFS_LEN_INC, {12'h800, l1});
    wr(1, OFS_LEN_INC, {12'h000, l2});
    rd(1, OFS_LEN_SUM, {12'h0, l1});
    rd(1, OFS_LEN, 32'h0);
    rd(0, OFS_LEN, lenword(l1));
    wr(1, OFS_LEN_INC, {12'h800, l2});
    rd(1, OFS_LEN, {12'h0, l1});
    rd(0, OFS_LEN, lenword(l1 + l2));
    tdone("length");
    d = $urandom;
    wr(0, OFS_H2S, d);
    rd(0, OFS_H2S, 32'h0);
    wr(1, OFS_H2S, ~d);
    repeat (20) quiet();
    @(negedge sys_clk);
    chk(h2s_vec, d & H2S_MASK);
    rd(1, OFS_H2S, d & H2S_MASK);
    wr(0, OFS_H2S, 32'h0);
    quiet();
    @(negedge sys_clk);
    chk(h2s_vec, 32'h0);
    tdone("vector");
    stop_test();
  end
endmodule
